// ### eeprom_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_checker_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    // Device status
    input wire logic write_busy,
    input wire logic write_protect
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_quiet; write_busy |-> !dev_sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("device drove sda while busy");
    property p_len; $rose(write_busy) |-> ##198 write_busy ##[1:3] !write_busy; endproperty
    a_len: assert property (p_len) else $error("write cycle length wrong");
    property p_gap; $fell(write_busy) |-> !write_busy [*8]; endproperty
    a_gap: assert property (p_gap) else $error("write cycle restarted");
    property p_stop; $rose(write_busy) |-> $past(scl) && sda; endproperty
    a_stop: assert property (p_stop) else $error("write cycle began without stop");
    property p_wp; $rose(write_busy) |-> !write_protect; endproperty
    a_wp: assert property (p_wp) else $error("write cycle while protected");
    property p_low; $changed(dev_sda_oe) |-> !scl; endproperty
    a_low: assert property (p_low) else $error("device sda moved while scl high");
    property p_hold; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
    a_hold: assert property (p_hold) else $error("device low bit too short");
    property p_free; dev_sda_oe |-> ##[1:240] !dev_sda_oe; endproperty
    a_free: assert property (p_free) else $error("device kept sda low");
    c_busy: cover property ($rose(write_busy));
    c_ack: cover property ($rose(dev_sda_oe));
    c_poll: cover property (write_busy && scl && $fell(sda));
endmodule : eeprom_checker_assertions
`default_nettype wire

// ### eeprom_device.sv
// Operation
// (RULE1) Host uses chip-select bits as A15-A17
// (RULE2) Sequential read never crosses into another device
// (RULE3) Reduced-pin variant: lower chip-selects sent zero
// (RULE4) Byte write: control, high, low address
// (RULE5) Write cycle starts at Stop; no acks
// (RULE6) Write-protected write acked, nothing written, ready
// (RULE7) After byte write pointer is next address
// (RULE8) Untouched page bytes rewritten with old contents
// (RULE9) Page bytes buffered, committed only after Stop
// (RULE10) Write increments only six low pointer bits
// (RULE11) Host keeps page writes inside one page; this host does not check, length past the page end is the caller's concern
// (RULE12) Protect input high blocks whole array writes
// (RULE13) Protect input sampled once at Stop
// (RULE14) Host polls with write control byte until acked; for a current read this host polls with the read control byte
// (RULE15) Read control byte has read bit one
// (RULE16) Current read returns byte after last accessed
// (RULE17) Random read: address write, restart, read
// (RULE18) After random read pointer is next address
// (RULE19) Master ack requests next byte; nack ends
// (RULE20) Read pointer rolls over top to bottom
// (RULE21) Respond only on type code and chip-select match
// (RULE22) Fifteen address bits; upper bits ignored
// (RULE23) Mismatch: no ack, ignore until next Start
`timescale 1ns/1ps
`default_nettype none

module eeprom_device #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Two-wire link
    link_if.device lnk,
    // Strap pins
    input wire logic chip_select_bit_low,
    input wire logic chip_select_bit_mid,
    input wire logic chip_select_bit_high,
    input wire logic write_protect,
    // Status
    output logic write_busy
);

    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_CTRL = 3'h1,
        D_AHI = 3'h3,
        D_ALO = 3'h2,
        D_WDAT = 3'h6,
        D_RDAT = 3'h7,
        D_SKIP = 3'h5
    } dstate_t;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic [1:0] wp_sy;
        logic [1:0][2:0] cs_sy;
        dstate_t st;
        dstate_t nxt;
        logic ack_ph;
        logic mack;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [eeprom_pkg::ADDR_W-1:0] ptr;
        logic [eeprom_pkg::PAGE_SIZE-1:0] loaded;
        logic have_data;
        logic busy;
        logic [eeprom_pkg::TIMER_W-1:0] timer;
        logic sda_oe;
        logic sda_o;
    } dev_t;

    localparam dev_t DEV_RESET = '{
        scl_sy: 3'h7,
        sda_sy: 3'h7,
        wp_sy: 2'h0,
        cs_sy: 6'h00,
        st: D_IDLE,
        nxt: D_IDLE,
        ack_ph: 1'h0,
        mack: 1'h0,
        bitn: 4'h0,
        sh: 8'h00,
        ptr: 15'h0000,
        loaded: 64'h0000_0000_0000_0000,
        have_data: 1'h0,
        busy: 1'h0,
        timer: 16'h0000,
        sda_oe: 1'h0,
        sda_o: 1'h0
    };

    localparam logic [eeprom_pkg::TIMER_W-1:0] WRITE_LOAD = WRITE_CYCLES[eeprom_pkg::TIMER_W-1:0];
    localparam logic [eeprom_pkg::TIMER_W-1:0] TIMER_LAST = 16'h0001;

    dev_t s;
    dev_t n;

    // The array and page buffer are kept outside the state record: they are never
    // reset, and copying 32K bytes through the next-state record would gain nothing.
    logic [7:0] mem [eeprom_pkg::MEM_SIZE];
    logic [7:0] pbuf [eeprom_pkg::PAGE_SIZE];

    logic scl_h;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_in;
    logic cs_match;
    logic pb_we;
    logic commit;
    logic [7:0] rd_byte;

    assign rd_byte = mem[s.ptr];

    always_comb begin
        n = s;
        pb_we = 1'b0;
        commit = 1'b0;
        n.scl_sy = {s.scl_sy[1:0], lnk.scl};
        n.sda_sy = {s.sda_sy[1:0], lnk.sda};
        n.wp_sy = {s.wp_sy[0], write_protect};
        n.cs_sy = {s.cs_sy[0], {chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low}};
        n.sda_o = 1'b0;
        scl_h = s.scl_sy[1] & s.scl_sy[2];
        scl_rise = s.scl_sy[1] & ~s.scl_sy[2];
        scl_fall = ~s.scl_sy[1] & s.scl_sy[2];
        start_seen = scl_h & s.sda_sy[2] & ~s.sda_sy[1];
        stop_seen = scl_h & ~s.sda_sy[2] & s.sda_sy[1];
        sda_in = s.sda_sy[1];
        cs_match = (s.sh[7:4] == eeprom_pkg::DEV_CODE) && (s.sh[3:1] == s.cs_sy[1]); // RULE21

        // Self-timed write cycle.
        if (s.busy) begin
            if (s.timer == TIMER_LAST) begin
                n.busy = 1'b0;
                commit = 1'b1; // RULE9
            end else begin
                n.timer = s.timer - TIMER_LAST;
            end
        end

        if (start_seen) begin
            // A repeated Start drops any unfinished write but keeps the pointer.
            n.st = D_CTRL; // RULE17 RULE23
            n.bitn = 4'h0;
            n.ack_ph = 1'b0;
            n.sda_oe = 1'b0;
            n.have_data = 1'b0;
        end else if (stop_seen) begin
            n.st = D_IDLE;
            n.ack_ph = 1'b0;
            n.sda_oe = 1'b0;
            n.have_data = 1'b0;
            // Protect is looked at only here, so later toggling cannot affect the cycle.
            if (s.have_data && !s.wp_sy[1]) begin // RULE6 RULE12 RULE13
                n.busy = 1'b1; // RULE5
                n.timer = WRITE_LOAD;
            end
        end else if (scl_rise) begin
            if (s.st != D_IDLE && s.st != D_SKIP) begin
                if (!s.ack_ph) begin
                    if (s.st != D_RDAT) begin
                        n.sh = {s.sh[6:0], sda_in};
                    end
                    n.bitn = s.bitn + 4'h1;
                end else if (s.st == D_RDAT) begin
                    n.mack = ~sda_in; // RULE19
                end
            end
        end else if (scl_fall) begin
            unique case (s.st)
                D_IDLE, D_SKIP: begin
                end
                D_CTRL, D_AHI, D_ALO, D_WDAT: begin
                    if (s.ack_ph) begin
                        n.ack_ph = 1'b0;
                        n.sda_oe = 1'b0;
                        n.bitn = 4'h0;
                        n.st = s.nxt;
                        if (s.nxt == D_RDAT) begin
                            n.sh = rd_byte; // RULE16
                            n.sda_oe = ~rd_byte[7];
                        end
                    end else if (s.bitn == eeprom_pkg::ACK_SLOT) begin
                        n.ack_ph = 1'b1;
                        n.sda_oe = 1'b1; // RULE4
                        unique case (s.st)
                            D_CTRL: begin
                                if (cs_match && !s.busy) begin // RULE5 RULE21
                                    n.nxt = (s.sh[0] == eeprom_pkg::RW_READ) ? D_RDAT : D_AHI; // RULE15
                                end else begin
                                    n.st = D_SKIP; // RULE23
                                    n.ack_ph = 1'b0;
                                    n.sda_oe = 1'b0;
                                end
                            end
                            D_AHI: begin
                                // The top bit of the high byte is dropped.
                                n.ptr[eeprom_pkg::ADDR_W-1:8] = s.sh[6:0]; // RULE22
                                n.nxt = D_ALO;
                            end
                            D_ALO: begin
                                n.ptr[7:0] = s.sh; // RULE17
                                n.loaded = '0;
                                n.nxt = D_WDAT;
                            end
                            default: begin
                                pb_we = 1'b1; // RULE9
                                n.loaded[s.ptr[eeprom_pkg::PAGE_W-1:0]] = 1'b1;
                                n.ptr[eeprom_pkg::PAGE_W-1:0] = s.ptr[eeprom_pkg::PAGE_W-1:0] + 6'h01; // RULE7 RULE10
                                n.have_data = 1'b1;
                                n.nxt = D_WDAT;
                            end
                        endcase
                    end
                end
                D_RDAT: begin
                    if (s.ack_ph) begin
                        if (s.mack) begin
                            n.ack_ph = 1'b0;
                            n.bitn = 4'h0;
                            n.sh = rd_byte; // RULE19
                            n.sda_oe = ~rd_byte[7];
                        end else begin
                            n.st = D_SKIP; // RULE16
                            n.sda_oe = 1'b0;
                        end
                    end else if (s.bitn == eeprom_pkg::ACK_SLOT) begin
                        n.sda_oe = 1'b0;
                        n.ack_ph = 1'b1;
                        n.mack = 1'b0;
                        // Full-width wrap stays inside this device's own array.
                        n.ptr = s.ptr + 15'h0001; // RULE2 RULE18 RULE20
                    end else begin
                        n.sh = {s.sh[6:0], 1'b0};
                        n.sda_oe = ~s.sh[6];
                    end
                end
                default: begin
                    n.st = D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= DEV_RESET;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (pb_we) begin
            pbuf[s.ptr[eeprom_pkg::PAGE_W-1:0]] <= s.sh;
        end
        if (commit) begin
            // The whole page is rewritten; bytes not sent keep their old value.
            for (int i = 0; i < eeprom_pkg::PAGE_SIZE; i++) begin
                mem[{s.ptr[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], i[eeprom_pkg::PAGE_W-1:0]}] <=
                    s.loaded[i] ? pbuf[i] :
                    mem[{s.ptr[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], i[eeprom_pkg::PAGE_W-1:0]}]; // RULE8
            end
        end
    end

    assign lnk.dev_sda_oe = s.sda_oe;
    assign lnk.dev_sda_o = s.sda_o;
    assign write_busy = s.busy;

endmodule : eeprom_device

`default_nettype wire

// ### eeprom_host.sv
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = eeprom_pkg::FIFO_WIDTH,
    parameter int DEPTH = eeprom_pkg::FIFO_DEPTH
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    // Pointers wrap by overflow, so DEPTH must be a power of two.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic in_rdy;
    } fifo_t;

    fifo_t s;
    fifo_t n;
    logic push;
    logic pop;

    always_comb begin
        n = s;
        push = in_valid & s.in_rdy;
        pop = out_ready & (s.cnt != '0);
        if (push) begin
            n.mem[s.wr] = in_data;
            n.wr = s.wr + 1'b1;
        end
        if (pop) begin
            n.rd = s.rd + 1'b1;
        end
        n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        n.in_rdy = n.cnt != DEPTH[AW:0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.in_rdy <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign in_ready = s.in_rdy;
    assign out_valid = s.cnt != '0;
    assign out_data = s.mem[s.rd];

endmodule : byte_fifo

module eeprom_host (
    // System
    input wire logic clk,
    input wire logic rst,
    // Two-wire link
    link_if.host lnk,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic cmd_current,
    input wire logic [2:0] cmd_cs,
    input wire logic [eeprom_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [eeprom_pkg::LEN_W-1:0] cmd_len,
    // Write data
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // Read data and completion
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done
);

    typedef enum logic [3:0] {
        H_IDLE = 4'h0,
        H_START = 4'h1,
        H_CTRL = 4'h3,
        H_AHI = 4'h2,
        H_ALO = 4'h6,
        H_WDAT = 4'h7,
        H_RST = 4'h5,
        H_RCTRL = 4'h4,
        H_RDAT = 4'hc,
        H_STOP = 4'hd
    } hstate_t;

    typedef struct packed {
        hstate_t st;
        logic [1:0] q;
        logic [eeprom_pkg::QCNT_W-1:0] qcnt;
        logic [3:0] bitn;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [eeprom_pkg::LEN_W-1:0] cnt;
        logic rd;
        logic cur;
        logic [2:0] cs;
        logic [eeprom_pkg::ADDR_W-1:0] addr;
        logic retry;
        logic [1:0] sda_sy;
        logic scl;
        logic sda_oe;
        logic sda_o;
        logic cmd_rdy;
        logic rd_valid;
        logic [7:0] rd_data;
        logic done;
    } host_t;

    localparam logic [eeprom_pkg::QCNT_W-1:0] QTR_LAST = eeprom_pkg::QTR_CYCLES[eeprom_pkg::QCNT_W-1:0] - 8'h01;
    localparam logic [eeprom_pkg::LEN_W-1:0] LEN_ONE = 7'h01;

    host_t s;
    host_t n;
    logic f_valid;
    logic f_pop;
    logic [7:0] f_data;
    logic ack;
    logic tick_end;
    logic need_byte;
    logic v1;
    logic v2;

    byte_fifo #(
        .WIDTH(eeprom_pkg::FIFO_WIDTH),
        .DEPTH(eeprom_pkg::FIFO_DEPTH)
    ) wr_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    always_comb begin
        n = s;
        f_pop = 1'b0;
        n.sda_sy = {s.sda_sy[0], lnk.sda};
        n.rd_valid = 1'b0;
        n.done = 1'b0;
        n.sda_o = 1'b0;
        ack = ~s.sda_sy[1];
        tick_end = s.qcnt == QTR_LAST;
        need_byte = ack && (s.bitn == eeprom_pkg::ACK_SLOT) &&
            ((s.st == H_ALO && !s.rd) || (s.st == H_WDAT && s.cnt != LEN_ONE));
        // Line values for the symbol: v1 from the second quarter, v2 in the last.
        v1 = 1'b1;
        v2 = 1'b1;
        unique case (s.st)
            H_START, H_RST: begin
                v2 = 1'b0;
            end
            H_STOP: begin
                v1 = 1'b0;
            end
            H_CTRL, H_AHI, H_ALO, H_WDAT, H_RCTRL: begin
                v1 = (s.bitn == eeprom_pkg::ACK_SLOT) ? 1'b1 : s.tx[3'h7 - s.bitn[2:0]];
                v2 = v1;
            end
            H_RDAT: begin
                v1 = (s.bitn == eeprom_pkg::ACK_SLOT) ? (s.cnt == LEN_ONE) : 1'b1; // RULE19
                v2 = v1;
            end
            default: begin
            end
        endcase

        if (s.st == H_IDLE) begin
            if (s.cmd_rdy && cmd_valid) begin
                n.st = H_START;
                // The first quarter keeps the idle levels, so the whole Start is played.
                n.q = 2'h0;
                n.qcnt = '0;
                n.rd = cmd_read | cmd_current;
                n.cur = cmd_current;
                n.cs = cmd_cs; // RULE1 RULE3
                n.addr = cmd_addr;
                n.cnt = cmd_len;
                n.retry = 1'b0;
            end
        end else if (!tick_end) begin
            n.qcnt = s.qcnt + 8'h01;
        end else if (!(s.q == 2'h3 && need_byte && !f_valid)) begin
            // The clock is held high at the end of an ack slot until data is queued.
            n.qcnt = '0;
            n.q = s.q + 2'h1;
            n.scl = n.q[1];
            if (n.q == 2'h1) begin
                n.sda_oe = ~v1;
            end else if (n.q == 2'h3) begin
                n.sda_oe = ~v2;
            end
            if (s.q == 2'h3) begin
                n.bitn = 4'h0;
                unique case (s.st)
                    H_START: begin
                        n.st = H_CTRL;
                        n.tx = {eeprom_pkg::DEV_CODE, s.cs, s.cur ? eeprom_pkg::RW_READ : eeprom_pkg::RW_WRITE}; // RULE4 RULE15
                    end
                    H_RST: begin
                        n.st = H_RCTRL;
                        n.tx = {eeprom_pkg::DEV_CODE, s.cs, eeprom_pkg::RW_READ}; // RULE17
                    end
                    H_STOP: begin
                        n.st = s.retry ? H_START : H_IDLE; // RULE14
                        n.retry = 1'b0;
                        n.done = ~s.retry;
                        // Between commands the clock rests high, as an idle bus needs.
                        n.scl = ~s.retry;
                    end
                    default: begin
                        if (s.bitn != eeprom_pkg::ACK_SLOT) begin
                            n.rx = {s.rx[6:0], s.sda_sy[1]};
                            n.bitn = s.bitn + 4'h1;
                        end else if (s.st == H_RDAT) begin
                            n.rd_valid = 1'b1;
                            n.rd_data = s.rx;
                            n.cnt = s.cnt - LEN_ONE;
                            n.st = (s.cnt == LEN_ONE) ? H_STOP : H_RDAT; // RULE19
                        end else if (!ack) begin
                            // A refused control byte means the write cycle is still running.
                            n.retry = s.st == H_CTRL; // RULE14
                            n.st = H_STOP;
                        end else begin
                            unique case (s.st)
                                H_CTRL: begin
                                    n.st = s.cur ? H_RDAT : H_AHI;
                                    n.tx = {1'b0, s.addr[eeprom_pkg::ADDR_W-1:8]}; // RULE4
                                end
                                H_AHI: begin
                                    n.st = H_ALO;
                                    n.tx = s.addr[7:0];
                                end
                                H_ALO: begin
                                    n.st = s.rd ? H_RST : H_WDAT; // RULE17
                                    f_pop = ~s.rd;
                                    n.tx = f_data;
                                end
                                H_WDAT: begin
                                    // Length beyond the page end is the caller's concern.
                                    n.cnt = s.cnt - LEN_ONE; // RULE9 RULE11
                                    n.st = (s.cnt == LEN_ONE) ? H_STOP : H_WDAT;
                                    f_pop = s.cnt != LEN_ONE;
                                    n.tx = f_data;
                                end
                                default: begin
                                    n.st = H_RDAT;
                                end
                            endcase
                        end
                    end
                endcase
            end
        end
        n.cmd_rdy = n.st == H_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.st <= H_IDLE;
            s.scl <= 1'b1;
            s.sda_sy <= 2'h3;
            s.cmd_rdy <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign lnk.scl = s.scl;
    assign lnk.host_sda_oe = s.sda_oe;
    assign lnk.host_sda_o = s.sda_o;
    assign cmd_ready = s.cmd_rdy;
    assign rd_valid = s.rd_valid;
    assign rd_data = s.rd_data;
    assign done = s.done;

endmodule : eeprom_host

`default_nettype wire

// ### eeprom_pkg.sv
`default_nettype none

package eeprom_pkg;

    // Clock and link timing.
    localparam int CLK_PERIOD_NS = 32'h0000_0064;
    localparam int WRITE_TIME_NS = 32'h004c_4b40;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCL_PERIOD_NS = 32'h0000_07d0;
    localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    // Addressing.
    localparam logic [3:0] DEV_CODE = 4'ha;
    localparam int ADDR_W = 32'h0000_000f;
    localparam int PAGE_W = 32'h0000_0006;
    localparam int PAGE_SIZE = 32'h0000_0040;
    localparam int MEM_SIZE = 32'h0000_8000;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic RW_READ = 1'h1;
    localparam logic RW_WRITE = 1'h0;

    // Widths of counters and user paths, and FIFO depth.
    localparam int TIMER_W = 32'h0000_0010;
    localparam int QCNT_W = 32'h0000_0008;
    localparam int LEN_W = 32'h0000_0007;
    localparam int FIFO_WIDTH = 32'h0000_0008;
    localparam int FIFO_DEPTH = 32'h0000_0004;

endpackage : eeprom_pkg

`default_nettype wire

// ### link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Open-drain wire with a pull-up: any enabled low driver wins.
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport host (
        output scl,
        output host_sda_o,
        output host_sda_oe,
        input sda
    );

    modport device (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface : link_if

`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, wp = 0, cv = 0, crd = 0, ccur = 0, wv = 0;
    logic rv, dn, cr, wrdy, busy;
    logic [2:0] cs = 3'h0, dcs = 3'h0;
    logic [14:0] ca = 15'h0000, ra;
    logic [6:0] cl = 7'h01;
    logic [7:0] wd = 8'h00, rdd;
    logic [7:0] mem [0:32767];
    logic [7:0] got [$];
    int errors = 0, compares = 0, cyc = 0, rn, seed = 32'h8ffb_9091;
    always #50 clk = ~clk;
    link_if lnk ();
    eeprom_host eeprom_host_inst (.clk(clk), .rst(rst), .lnk(lnk.host), .cmd_valid(cv),
        .cmd_ready(cr), .cmd_read(crd), .cmd_current(ccur), .cmd_cs(cs), .cmd_addr(ca),
        .cmd_len(cl), .wr_valid(wv), .wr_ready(wrdy), .wr_data(wd), .rd_valid(rv),
        .rd_data(rdd), .done(dn));
    eeprom_device #(.WRITE_CYCLES(200)) eeprom_device_inst (.clk(clk), .rst(rst),
        .lnk(lnk.device), .chip_select_bit_low(dcs[0]), .chip_select_bit_mid(dcs[1]),
        .chip_select_bit_high(dcs[2]), .write_protect(wp), .write_busy(busy));
    eeprom_checker_assertions eeprom_checker_assertions_inst (.clk(clk), .rst(rst),
        .scl(lnk.scl), .sda(lnk.sda), .dev_sda_oe(lnk.dev_sda_oe), .write_busy(busy),
        .write_protect(wp));
    task automatic close_out();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // The ceiling covers about twice the expected run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rv === 1'b1) got.push_back(rdd);
        if (cyc == 60000) begin
            errors++;
            close_out();
        end
    end
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s exp=%h got=%h", what, exp, seen);
        end
    endtask : cmp
    function automatic logic [14:0] pg(logic [14:0] a, int i);
        return {a[14:6], 6'(int'(a[5:0]) + i)};
    endfunction : pg
    task automatic go(logic r, logic c, logic [14:0] a, int n);
        @(negedge clk);
        crd = r;
        ccur = c;
        ca = a;
        cl = 7'(n);
        cv = 1;
        while (cr !== 1'b1) @(negedge clk);
        @(negedge clk);
        cv = 0;
        while (dn !== 1'b1) @(negedge clk);
    endtask : go
    task automatic wr(logic [14:0] a, int n);
        fork
            go(1'b0, 1'b0, a, n);
            begin
                @(negedge clk);
                wv = 1;
                for (int i = 0; i < n; i++) begin
                    if (i == 4) cmp("fifo_ready", 8'h00, 8'(wrdy));
                    wd = 8'($random(seed));
                    if (!wp) mem[pg(a, i)] = wd;
                    while (wrdy !== 1'b1) @(negedge clk);
                    @(negedge clk);
                end
                wv = 0;
            end
        join
    endtask : wr
    task automatic rd(logic c, logic [14:0] a, int n);
        got.delete();
        go(1'b1, c, a, n);
        cmp("rd_count", 8'(n), 8'(got.size()));
        for (int i = 0; i < n; i++) cmp("rd_data", mem[15'(a + i)], got[i]);
    endtask : rd
    task automatic settle(int n);
        repeat (n) @(negedge clk);
    endtask : settle
    initial begin
        cs = 3'($random(seed));
        dcs = cs;
        settle(8);
        rst = 0;
        settle(5);
        wr(15'h1234, 1);
        settle(5);
        cmp("busy", 8'h01, 8'(busy));
        wr(15'h1233, 1);
        rd(1'b1, 15'h1234, 1);
        wr(15'h057e, 5);
        wr(15'h0541, 1);
        rd(1'b0, 15'h0540, 3);
        rd(1'b0, 15'h057e, 1);
        rd(1'b1, 15'h057f, 1);
        wr(15'h7fff, 1);
        wr(15'h0000, 1);
        rd(1'b0, 15'h7fff, 2);
        settle(300);
        wp = 1;
        settle(5);
        wr(15'h1233, 2);
        settle(5);
        cmp("busy", 8'h00, 8'(busy));
        wp = 0;
        rd(1'b0, 15'h1233, 2);
        wr(15'h2000, 1);
        settle(10);
        wp = 1;
        settle(300);
        wp = 0;
        rd(1'b0, 15'h2000, 1);
        // The host polls a foreign select until the straps are moved to match it.
        dcs = cs ^ 3'h4;
        fork
            wr(15'h0a00, 1);
            begin
                rn = 0;
                repeat (600) begin
                    @(negedge clk);
                    if (lnk.dev_sda_oe) rn++;
                end
                cmp("mismatch_ack", 8'h00, 8'(rn));
                dcs = cs;
            end
        join
        rd(1'b0, 15'h0a00, 1);
        cs = cs & 3'h4;
        dcs = cs;
        repeat (4) begin
            ra = 15'($random(seed)) & 15'h7fdf;
            rn = 1 + ($random(seed) & 3);
            wr(ra, rn);
            rd(1'b0, ra, rn);
        end
        close_out();
    end
endmodule : tb
`default_nettype wire
